// ---- core/cbstr_top.v ----
/*
 * processor-bus target response of a system controller that shares the
 * bus with an L2 cache and up to three sibling controllers.
 * assumes bus inputs are synchronous to CORE_CLK; straps are async pins.
 */
`timescale 1ns/10ps
`include "cbstr_defines.vh"

module cbstr_top (
   input  wire        CORE_CLK,           // processor bus clock
   input  wire        SYS_RST,            // synchronous reset, active high
   input  wire        TS_N,               // transfer start
   input  wire        READ_IN,            // 1 read, 0 write
   input  wire        TBST_N,             // burst transfer
   input  wire [31:0] ADDR_IN,            // shared address lines
   input  wire [31:0] DATA_IN,            // shared data lines
   input  wire        AACK_I,             // address acknowledge wire
   input  wire        TA_I,               // transfer acknowledge wire
   input  wire        ARTRY_N,            // address retry
   input  wire        CACHE_HIT_N,        // cache_hit_in
   input  wire        CACHE_BR_N,         // cache bus request
   input  wire        DECODE_HIT,         // normal window hit
   input  wire        DECODE_REG,         // normal hit is register space
   input  wire        DATA_READY,         // memory side has a beat
   input  wire        MULTI_STRAP,        // multi-device strap pin
   input  wire        READY_STRAP,        // wait-ready strap, id bit 1
   input  wire        CS_TIMING_STRAP,    // cs_timing_strap, id bit 0
   output wire        AACK_O,             // address acknowledge level
   output wire        AACK_OE,            // address acknowledge enable
   output wire        TA_O,               // transfer acknowledge level
   output wire        TA_OE,              // transfer acknowledge enable
   output reg         BG_N,               // cpu address grant
   output reg         DBG_N,              // cpu data grant
   output reg         CACHE_ADDR_GRANT_N, // cache_addr_grant
   output reg         CACHE_DATA_GRANT_N, // cache_data_grant
   output reg         ADDR_SWITCH_ENABLE, // addr_switch_enable
   output reg         BOOT_CHIP_SELECT_N, // boot_chip_select
   output reg         EXT_ACCESS,         // memory side data phase
   output reg  [31:0] RD_DATA,            // register read data
   output reg         RD_DATA_OE          // read data enable
);

   // ==========================================================
   // states
   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_ADDR  = 3'h1;
   localparam [2:0] S_POST  = 3'h2;
   localparam [2:0] S_DATA  = 3'h3;
   localparam [2:0] S_TURN  = 3'h4;
   localparam [2:0] S_WATCH = 3'h5;
   localparam [2:0] S_WDATA = 3'h6;

   reg  [2:0]  st_s1_q;          // strap synchroniser stage 1
   reg  [2:0]  st_s2_q;          // strap synchroniser stage 2
   reg  [2:0]  st_s3_q;          // strap synchroniser stage 3
   reg  [31:0] cfg_q;            // processor_interface_config
   reg  [1:0]  id_q;             // device_id_field
   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg  [2:0]  cnt_q;            // cycles since transfer start
   reg  [2:0]  cnt_d;
   reg  [1:0]  kind_q;
   reg  [1:0]  kind_d;
   reg         read_q;
   reg         read_d;
   reg  [2:0]  beats_q;          // beats left
   reg  [2:0]  beats_d;
   reg  [11:0] ofs_q;
   reg  [11:0] ofs_d;
   reg         own_q;            // this controller answers
   reg         own_d;
   reg         acked_q;          // address acknowledge fired
   reg         acked_d;
   reg         cache_hit_in_q;          // cache claimed the transaction
   reg         cache_hit_in_d;
   reg         owner_q;          // 1 when the cache is bus master
   reg         owner_d;
   reg  [11:0] mt_q;             // miss timeout counter
   reg  [11:0] mt_d;
   reg         wr_pend_q;        // register write beat on the bus now
   reg         aack_go;
   reg         ta_go;
   reg  [1:0]  kind_now;
   reg  [31:0] rd_mux;
   wire        multi;
   wire        boot;
   wire        l2pres;
   wire [2:0]  win;
   wire [2:0]  ack_cyc;
   wire        ready;
   wire        retry;

   // ==========================================================
   // configuration decode
   assign multi   = cfg_q[`CBSTR_CFG_MULTI];
   assign boot    = !multi || (id_q == `CBSTR_ID_BOOT);
   assign l2pres  = cfg_q[`CBSTR_CFG_L2PRES];
   assign win     = cfg_q[`CBSTR_CFG_HITWIN] ? `CBSTR_CYC_TWO
                                              : `CBSTR_CYC_ONE;
   // acknowledge must follow the cache hit sample
   assign ack_cyc = l2pres ? win + `CBSTR_CYC_ONE
                  : (cfg_q[`CBSTR_CFG_ACKDLY] ? `CBSTR_CYC_ONE
                                              : `CBSTR_CYC_TWO);
   assign ready   = (kind_q == `CBSTR_K_REG) ||
                    (kind_q == `CBSTR_K_NONE) || DATA_READY;
   assign retry   = !ARTRY_N && (cnt_q >= `CBSTR_CYC_TWO);

   // ==========================================================
   // strap synchroniser, three stages
   always @(posedge CORE_CLK) begin
      st_s1_q <= {MULTI_STRAP, READY_STRAP, CS_TIMING_STRAP};
      st_s2_q <= st_s1_q;
      st_s3_q <= st_s2_q;
   end

   // ==========================================================
   // target decode of the address on the bus
   always @* begin
      kind_now = `CBSTR_K_NONE;
      if (multi) begin
         if (ADDR_IN[`CBSTR_A_ID] == id_q) begin
            if (!READ_IN || !ADDR_IN[`CBSTR_A_BOOTSEL])
               kind_now = `CBSTR_K_REG;
            else
               kind_now = `CBSTR_K_BOOT;
         end
      end else if (DECODE_HIT) begin
         kind_now = DECODE_REG ? `CBSTR_K_REG : `CBSTR_K_EXT;
      end
   end

   // ==========================================================
   // register read mux
   always @* begin
      case (ofs_q)
         `CBSTR_OFS_CFG: rd_mux = cfg_q;
         `CBSTR_OFS_ID:  rd_mux = {`CBSTR_ID_PAD, id_q};
         default:        rd_mux = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // transaction state machine
   always @* begin
      state_d = state_q;
      cnt_d   = (cnt_q == `CBSTR_CYC_MAX) ? cnt_q
                                          : cnt_q + `CBSTR_CYC_ONE;
      kind_d  = kind_q;
      read_d  = read_q;
      beats_d = beats_q;
      ofs_d   = ofs_q;
      own_d   = own_q;
      acked_d = acked_q;
      cache_hit_in_d = cache_hit_in_q;
      owner_d = owner_q;
      mt_d    = mt_q;
      aack_go = 1'b0;
      ta_go   = 1'b0;
      case (state_q)
         S_IDLE: begin
            cnt_d = `CBSTR_CYC_ONE;
            if (!TS_N) begin
               kind_d  = kind_now;
               read_d  = READ_IN;
               beats_d = TBST_N ? `CBSTR_BEATS_SINGLE
                                : `CBSTR_BEATS_BURST;
               ofs_d   = ADDR_IN[`CBSTR_A_OFS];
               own_d   = (kind_now != `CBSTR_K_NONE);
               acked_d = 1'b0;
               cache_hit_in_d = 1'b0;
               owner_d = !CACHE_ADDR_GRANT_N;
               mt_d    = `CBSTR_MT_ZERO;
               if (kind_now != `CBSTR_K_NONE) begin
                  state_d = S_ADDR;
                  if (ack_cyc == `CBSTR_CYC_ONE) begin
                     aack_go = 1'b1;
                     acked_d = 1'b1;
                  end
               end else begin
                  state_d = S_WATCH;
               end
            end
         end
         S_ADDR: begin
            if (l2pres && !acked_q && cnt_q == win &&
                !CACHE_HIT_N) begin
               kind_d  = `CBSTR_K_NONE;
               own_d   = 1'b0;
               cache_hit_in_d = 1'b1;
               state_d = S_WATCH;
            end else if (retry) begin
               state_d = S_TURN;
            end else if (acked_q) begin
               state_d = S_POST;
            end else if (cnt_q == ack_cyc - `CBSTR_CYC_ONE) begin
               aack_go = 1'b1;
               acked_d = 1'b1;
            end
         end
         S_POST: begin
            // one more retry sample cycle after the acknowledge
            if (!ARTRY_N)
               state_d = S_TURN;
            else
               state_d = own_q ? S_DATA : S_WDATA;
         end
         S_DATA: begin
            if (ready) begin
               ta_go   = 1'b1;
               beats_d = beats_q - `CBSTR_CYC_ONE;
               if (beats_q == `CBSTR_CYC_ONE)
                  state_d = S_TURN;
            end
         end
         S_WATCH: begin
            mt_d = mt_q + `CBSTR_MT_ONE;
            if (retry) begin
               state_d = S_TURN;
            end else if (!AACK_I) begin
               state_d = S_POST;
            end else if (boot && cfg_q[`CBSTR_CFG_MTEN] && !cache_hit_in_q &&
                         mt_q == cfg_q[`CBSTR_CFG_MTCNT]) begin
               aack_go = 1'b1;
               acked_d = 1'b1;
               own_d   = 1'b1;
               state_d = S_ADDR;
            end
         end
         S_WDATA: begin
            if (!TA_I) begin
               beats_d = beats_q - `CBSTR_CYC_ONE;
               if (beats_q == `CBSTR_CYC_ONE)
                  state_d = S_TURN;
            end
         end
         S_TURN: begin
            state_d = S_IDLE;
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
   end

   // ==========================================================
   // state registers
   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         state_q <= S_IDLE;
         cnt_q   <= `CBSTR_CYC_ONE;
         kind_q  <= `CBSTR_K_NONE;
         read_q  <= 1'b0;
         beats_q <= `CBSTR_BEATS_SINGLE;
         ofs_q   <= `CBSTR_OFS_CFG;
         own_q   <= 1'b0;
         acked_q <= 1'b0;
         cache_hit_in_q <= 1'b0;
         owner_q <= 1'b0;
         mt_q    <= `CBSTR_MT_ZERO;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         kind_q  <= kind_d;
         read_q  <= read_d;
         beats_q <= beats_d;
         ofs_q   <= ofs_d;
         own_q   <= own_d;
         acked_q <= acked_d;
         cache_hit_in_q <= cache_hit_in_d;
         owner_q <= owner_d;
         mt_q    <= mt_d;
      end
   end

   // ==========================================================
   // registers: straps at reset, then bus writes
   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         wr_pend_q <= 1'b0;
         cfg_q     <= `CBSTR_CFG_RST;
         id_q      <= `CBSTR_ID_RST;
         if (st_s2_q == st_s3_q) begin
            cfg_q[`CBSTR_CFG_MULTI] <= st_s3_q[2];
            id_q                    <= st_s3_q[1:0];
         end
      end else begin
         wr_pend_q <= ta_go && !read_q && (kind_q == `CBSTR_K_REG);
         if (wr_pend_q && ofs_q == `CBSTR_OFS_CFG)
            cfg_q <= DATA_IN;
         if (wr_pend_q && ofs_q == `CBSTR_OFS_ID)
            id_q <= DATA_IN[1:0];
      end
   end

   // ==========================================================
   // read data, chip selects and grants
   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         RD_DATA            <= 32'h0000_0000;
         RD_DATA_OE         <= 1'b0;
         BOOT_CHIP_SELECT_N <= 1'b1;
         EXT_ACCESS         <= 1'b0;
         BG_N               <= 1'b1;
         CACHE_ADDR_GRANT_N <= 1'b1;
         DBG_N              <= 1'b1;
         CACHE_DATA_GRANT_N <= 1'b1;
         ADDR_SWITCH_ENABLE <= 1'b0;
      end else begin
         RD_DATA    <= (kind_q == `CBSTR_K_REG) ? rd_mux
                                                : 32'h0000_0000;
         RD_DATA_OE <= ta_go && read_q &&
                       (kind_q == `CBSTR_K_REG ||
                        kind_q == `CBSTR_K_NONE);
         BOOT_CHIP_SELECT_N <= !(state_d == S_DATA &&
                                 kind_d == `CBSTR_K_BOOT);
         EXT_ACCESS <= (state_d == S_DATA) &&
                       (kind_d == `CBSTR_K_EXT);
         // address grant only in idle, never beside a data grant
         BG_N <= !(boot && state_d == S_IDLE &&
                   CACHE_BR_N);
         CACHE_ADDR_GRANT_N <= !(boot && state_d == S_IDLE &&
                                 !CACHE_BR_N);
         DBG_N <= !(boot && !owner_d && (state_d == S_DATA ||
                    state_d == S_WDATA));
         CACHE_DATA_GRANT_N <= !(boot && owner_d &&
                                 (state_d == S_DATA ||
                                  state_d == S_WDATA));
         ADDR_SWITCH_ENABLE <= boot && (state_d == S_IDLE ||
                                        state_d == S_ADDR ||
                                        state_d == S_WATCH);
      end
   end

   // ==========================================================
   // acknowledge pin drivers
   cbstr_ack_drv u_aack (
      .clk    (CORE_CLK),
      .rst    (SYS_RST),
      .fire   (aack_go),
      .pin_o  (AACK_O),
      .pin_oe (AACK_OE)
   );

   cbstr_ack_drv u_ta (
      .clk    (CORE_CLK),
      .rst    (SYS_RST),
      .fire   (ta_go),
      .pin_o  (TA_O),
      .pin_oe (TA_OE)
   );

endmodule // cbstr_top

// ---- core/cbstr_defines.vh ----
/*
 * constants of the shared-bus target-response block: register offsets,
 * field positions, reset values, address-line positions and beat counts.
 * assumes processor bit n of the address bus is bit (31-n) of ADDR_IN.
 */
`ifndef CBSTR_DEFINES_VH
`define CBSTR_DEFINES_VH

// ==========================================================
// register offsets (address bits 20-31)
`define CBSTR_OFS_CFG       12'h000
`define CBSTR_OFS_ID        12'h120

// ==========================================================
// processor_interface_config fields
`define CBSTR_CFG_RST       32'h0000_0000
`define CBSTR_CFG_MTCNT     11:0
`define CBSTR_CFG_MTEN      12
`define CBSTR_CFG_HITWIN    15
`define CBSTR_CFG_ACKDLY    16
`define CBSTR_CFG_L2PRES    17
`define CBSTR_CFG_MULTI     18

// ==========================================================
// multi_device_id fields
`define CBSTR_ID_RST        2'h0
`define CBSTR_ID_BOOT       2'h3
`define CBSTR_ID_PAD        30'h0000_0000

// ==========================================================
// address line positions
`define CBSTR_A_ID          26:25
`define CBSTR_A_BOOTSEL     27
`define CBSTR_A_OFS         11:0

// ==========================================================
// transaction timing and beats
`define CBSTR_BEATS_BURST   3'h4
`define CBSTR_BEATS_SINGLE  3'h1
`define CBSTR_CYC_ONE       3'h1
`define CBSTR_CYC_TWO       3'h2
`define CBSTR_CYC_MAX       3'h7
`define CBSTR_MT_ZERO       12'h000
`define CBSTR_MT_ONE        12'h001

// ==========================================================
// target kinds
`define CBSTR_K_NONE        2'h0
`define CBSTR_K_REG         2'h1
`define CBSTR_K_BOOT        2'h2
`define CBSTR_K_EXT         2'h3

`endif

// ---- core/cbstr_ack_drv.v ----
/*
 * sustained tri-state driver for one acknowledge pin.
 * assumes an external pull-up holds the wire high while released.
 */
`timescale 1ns/10ps

module cbstr_ack_drv (
   input  wire clk,    // processor bus clock
   input  wire rst,    // synchronous reset, active high
   input  wire fire,   // drive the pin low next cycle
   output reg  pin_o,  // pin output level
   output reg  pin_oe  // pin output enable, high while driving
);

   reg was_low_q;   // pin was low in the current cycle

   // ==========================================================
   // low while fired, one high cycle after the last low, then release
   always @(posedge clk) begin
      if (rst) begin
         pin_o     <= 1'b1;
         pin_oe    <= 1'b0;
         was_low_q <= 1'b0;
      end else if (fire) begin
         pin_o     <= 1'b0;
         pin_oe    <= 1'b1;
         was_low_q <= 1'b1;
      end else if (was_low_q) begin
         pin_o     <= 1'b1;
         pin_oe    <= 1'b1;
         was_low_q <= 1'b0;
      end else begin
         pin_o     <= 1'b1;
         pin_oe    <= 1'b0;
      end
   end

endmodule // cbstr_ack_drv

// ---- dv/cbstr_checker.sv ----
/* pin assertions for the shared-bus target response block.
   assumes a bind to cbstr_top, one clock and a synchronous reset. */
`timescale 1ns/10ps

module cbstr_checker (
   input wire CORE_CLK,           // bus clock
   input wire SYS_RST,            // sync reset
   input wire TS_N,               // transfer start
   input wire ARTRY_N,            // address retry
   input wire CACHE_HIT_N,        // cache hit
   input wire AACK_O,             // aack level
   input wire AACK_OE,            // aack enable
   input wire TA_O,               // ta level
   input wire TA_OE,              // ta enable
   input wire BG_N,               // cpu address grant
   input wire DBG_N,              // cpu data grant
   input wire CACHE_ADDR_GRANT_N, // cache address grant
   input wire CACHE_DATA_GRANT_N, // cache data grant
   input wire RD_DATA_OE,         // read data enable
   input wire ADDR_SWITCH_ENABLE, // address switch enable
   input wire EXT_ACCESS          // memory side data phase
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   // ==========================================================
   // acknowledge pins
   chk_aack_high_release: assert property (
      (AACK_OE && !AACK_O) |=> (AACK_OE && AACK_O) ##1 !AACK_OE)
      else $error("aack not driven high once then released");
   chk_ta_starts_low: assert property (
      $rose(TA_OE) |-> !TA_O)
      else $error("ta enabled at a high level");
   chk_ta_after_retry: assert property (
      (AACK_OE && !AACK_O) |=> !TA_OE [*2])
      else $error("ta inside the retry window");
   chk_retry_drops: assert property (
      (AACK_OE && AACK_O && !ARTRY_N) |=> !TA_OE [*8])
      else $error("ta after a retried transaction");
   chk_hit_quiet: assert property (
      (!TS_N ##1 !CACHE_HIT_N ##1 !CACHE_HIT_N) |-> !AACK_OE [*6])
      else $error("aack driven on a cache hit");
   chk_read_with_ta: assert property (
      RD_DATA_OE |-> TA_OE && !TA_O)
      else $error("read data outside a ta beat");

   // ==========================================================
   // grants
   chk_addr_grants: assert property (
      !(!BG_N && !CACHE_ADDR_GRANT_N))
      else $error("two address grants");
   chk_data_grants: assert property (
      !(!DBG_N && !CACHE_DATA_GRANT_N))
      else $error("two data grants");
   chk_bus_apart: assert property (
      !(BG_N && CACHE_ADDR_GRANT_N) |-> DBG_N && CACHE_DATA_GRANT_N)
      else $error("address and data grants overlap");
   chk_switch_off: assert property (
      (!DBG_N || !CACHE_DATA_GRANT_N) |-> !ADDR_SWITCH_ENABLE)
      else $error("address switch on during a data tenure");
   chk_ext_data: assert property (
      EXT_ACCESS |-> !(DBG_N && CACHE_DATA_GRANT_N))
      else $error("memory access outside the data grant");
endmodule // cbstr_checker

bind cbstr_top cbstr_checker cbstr_checker_i (
   .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .TS_N(TS_N),
   .ARTRY_N(ARTRY_N), .CACHE_HIT_N(CACHE_HIT_N), .AACK_O(AACK_O),
   .AACK_OE(AACK_OE), .TA_O(TA_O), .TA_OE(TA_OE), .BG_N(BG_N),
   .DBG_N(DBG_N), .CACHE_ADDR_GRANT_N(CACHE_ADDR_GRANT_N),
   .CACHE_DATA_GRANT_N(CACHE_DATA_GRANT_N), .RD_DATA_OE(RD_DATA_OE),
   .ADDR_SWITCH_ENABLE(ADDR_SWITCH_ENABLE), .EXT_ACCESS(EXT_ACCESS));

// ---- dv/cbstr_master_model.sv ----
/* processor bus master model: one single-beat transfer per start pulse.
   assumes acknowledge inputs are the resolved wires, active low. */
`timescale 1ns/10ps

module cbstr_master_model (
   input  wire        clk,    // bus clock
   input  wire        rst,    // sync reset
   input  wire        go,     // start one transfer
   input  wire        rd,     // 1 read
   input  wire [31:0] addr,   // target address
   input  wire [31:0] wdata,  // write data
   input  wire        retry,  // transfer ends at address acknowledge
   input  wire        aack_w, // address acknowledge wire
   input  wire        ta_w,   // transfer acknowledge wire
   input  wire [31:0] rd_bus, // read data from target
   output reg         ts_n,   // transfer start
   output reg         read_o, // read flag
   output wire        tbst_n, // burst flag, always single
   output reg  [31:0] addr_o, // address lines
   output reg  [31:0] data_o, // data lines
   output reg  [31:0] rdata,  // captured read data
   output reg         done    // one-cycle end of transfer
);
   reg [1:0] st_q; // idle, address, data, end

   assign tbst_n = 1'b1;

   // ==========================================================
   // hold the request until acknowledged, released lines invert
   always @(posedge clk) begin
      done <= 1'b0;
      ts_n <= 1'b1;
      if (rst) begin
         st_q <= 2'h0;
      end else begin
         case (st_q)
         2'h0: if (go) begin
            ts_n   <= 1'b0;
            read_o <= rd;
            addr_o <= addr;
            data_o <= wdata;
            st_q   <= 2'h1;
         end
         2'h1: if (!aack_w) st_q <= retry ? 2'h3 : 2'h2;
         2'h2: if (!ta_w) begin
            rdata <= rd_bus;
            st_q  <= 2'h3;
         end
         default: begin
            done   <= 1'b1;
            addr_o <= ~addr_o;
            data_o <= ~data_o;
            st_q   <= 2'h0;
         end
         endcase
      end
   end
endmodule // cbstr_master_model

// ---- dv/test_cbstr_top.sv ----
/* self-checking bench for cbstr_top with a master model and a cache
   acknowledging in its place. assumes a 200 MHz clock. */
`timescale 1ns/10ps

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
   fail_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module test_cbstr_top;
   reg clk = 0, rst = 1, go = 0, m_rd = 0, m_rt = 0, artry_n = 1;
   reg hit_n = 1, c_aack_n = 1, c_ta_n = 1, dec = 0, dreg = 0, br_n = 1;
   reg s_multi = 1, s_rdy = 1, s_cs = 1;
   reg [31:0] m_addr = 0, m_wd = 0;
   wire ts_n, rd, tbst_n, aack_o, aack_oe, ta_o, ta_oe, done, bcs_n;
   wire ext, bg_n, cg_n;
   wire [31:0] addr, data, rdd, rdata;
   wire aack_w = (aack_oe ? aack_o : 1'b1) & c_aack_n; // pull-up
   wire ta_w   = (ta_oe ? ta_o : 1'b1) & c_ta_n;
   integer fail_count = 0, comparisons = 0, cyc = 0, lat = 0;
   integer oe_cnt = 0, bcs_cnt = 0, ext_cnt = 0;

   always #2.5 clk = ~clk;

   cbstr_master_model cbstr_master_model_i (.clk(clk), .rst(rst),
      .go(go), .rd(m_rd), .addr(m_addr), .wdata(m_wd), .retry(m_rt),
      .aack_w(aack_w), .ta_w(ta_w), .rd_bus(rdd), .ts_n(ts_n),
      .read_o(rd), .tbst_n(tbst_n), .addr_o(addr), .data_o(data),
      .rdata(rdata), .done(done));

   cbstr_top cbstr_top_i (.CORE_CLK(clk), .SYS_RST(rst), .TS_N(ts_n),
      .READ_IN(rd), .TBST_N(tbst_n), .ADDR_IN(addr), .DATA_IN(data),
      .AACK_I(aack_w), .TA_I(ta_w), .ARTRY_N(artry_n),
      .CACHE_HIT_N(hit_n), .CACHE_BR_N(br_n), .DECODE_HIT(dec),
      .DECODE_REG(dreg), .DATA_READY(1'b1), .MULTI_STRAP(s_multi),
      .READY_STRAP(s_rdy), .CS_TIMING_STRAP(s_cs), .AACK_O(aack_o),
      .AACK_OE(aack_oe), .TA_O(ta_o), .TA_OE(ta_oe), .BG_N(bg_n),
      .DBG_N(), .CACHE_ADDR_GRANT_N(cg_n), .CACHE_DATA_GRANT_N(),
      .ADDR_SWITCH_ENABLE(), .BOOT_CHIP_SELECT_N(bcs_n),
      .EXT_ACCESS(ext), .RD_DATA(rdd), .RD_DATA_OE());

   // ==========================================================
   // acknowledge latency and activity since the last start
   always @(posedge clk) begin
      cyc <= ts_n ? cyc + 1 : 1;
      oe_cnt <= ts_n ? oe_cnt + (aack_oe === 1'b1) : 0;
      bcs_cnt <= ts_n ? bcs_cnt + (bcs_n === 1'b0) : 0;
      ext_cnt <= ts_n ? ext_cnt + (ext === 1'b1) : 0;
      if (aack_oe === 1'b1 && aack_o === 1'b0) lat <= cyc;
   end

   task results;
      begin
         $display("comparisons %0d fail_count %0d", comparisons, fail_count);
         if (fail_count == 0 && comparisons > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask

   task reset_dut(input m, input r, input c);
      begin
         s_multi <= m;
         s_rdy <= r;
         s_cs <= c;
         rst <= 1'b1;
         repeat (4) @(posedge clk);
         rst <= 1'b0;
         @(posedge clk);
      end
   endtask

   // one transfer; h makes the cache claim it with a hit
   task xfer(input r, input [1:0] id, input a4, input [11:0] ofs,
             input [31:0] wd, input rt, input h);
      integer n;
      begin
         n = 0;
         go <= 1'b1;
         m_rd <= r;
         m_addr <= {4'h0, a4, id, 13'h0000, ofs};
         m_wd <= wd;
         m_rt <= rt;
         artry_n <= !rt;
         hit_n <= !h;
         @(posedge clk);
         go <= 1'b0;
         if (h) begin
            repeat (3) @(posedge clk);
            c_aack_n <= 1'b0;
            @(posedge clk);
            c_aack_n <= 1'b1;
            repeat (2) @(posedge clk);
            c_ta_n <= 1'b0;
            @(posedge clk);
            c_ta_n <= 1'b1;
         end
         while (done !== 1'b1 && n < 200) begin
            @(posedge clk);
            n = n + 1;
         end
         `CHK(n < 200, 1'b1)
         artry_n <= 1'b1;
         hit_n <= 1'b1;
         // idle gap so address and data tenures never meet
         repeat (2) @(posedge clk);
      end
   endtask

   task t_reset_regs;
      begin
         xfer(1, 2'h3, 0, 12'h000, 0, 0, 0);
         `CHK(rdata, 32'h0004_0000)
         `CHK(lat, 2)
         `CHK(bcs_cnt, 0)
         xfer(1, 2'h3, 0, 12'h120, 0, 0, 0);
         `CHK(rdata, 32'h0000_0003)
      end
   endtask

   task t_id_write;
      begin
         xfer(0, 2'h3, 0, 12'h120, 32'h0000_0001, 0, 0);
         xfer(1, 2'h1, 0, 12'h120, 0, 0, 0);
         `CHK(rdata, 32'h0000_0001)
         xfer(0, 2'h1, 1, 12'h120, 32'h0000_0003, 0, 0);
         xfer(1, 2'h3, 0, 12'h120, 0, 0, 0);
         `CHK(rdata, 32'h0000_0003)
      end
   endtask

   task t_retry;
      begin
         xfer(0, 2'h3, 0, 12'h120, 32'h0000_0002, 1, 0);
         xfer(1, 2'h3, 0, 12'h120, 0, 0, 0);
         `CHK(rdata, 32'h0000_0003)
      end
   endtask

   task t_cache;
      begin
         br_n <= 1'b0;
         repeat (2) @(posedge clk);
         `CHK(cg_n, 1'b0)
         `CHK(bg_n, 1'b1)
         br_n <= 1'b1;
         @(posedge clk);
         xfer(0, 2'h3, 0, 12'h000, 32'h0006_0000, 0, 0);
         xfer(1, 2'h3, 0, 12'h000, 0, 0, 0);
         `CHK(lat, 2)
         xfer(0, 2'h3, 0, 12'h120, 32'h0000_0000, 0, 1);
         `CHK(oe_cnt, 0)
         xfer(1, 2'h3, 0, 12'h120, 0, 0, 0);
         `CHK(rdata, 32'h0000_0003)
         xfer(0, 2'h3, 0, 12'h000, 32'h0006_8000, 0, 0);
         xfer(1, 2'h3, 0, 12'h000, 0, 0, 0);
         `CHK(lat, 3)
         `CHK(rdata, 32'h0006_8000)
      end
   endtask

   task t_delay_boot;
      begin
         xfer(0, 2'h3, 0, 12'h000, 32'h0005_0000, 0, 0);
         xfer(1, 2'h3, 0, 12'h000, 0, 0, 0);
         `CHK(lat, 1)
         xfer(1, 2'h3, 1, 12'h100, 0, 0, 0);
         `CHK(bcs_cnt > 0, 1'b1)
      end
   endtask

   task t_miss;
      begin
         xfer(0, 2'h3, 0, 12'h000, 32'h0004_1005, 0, 0);
         xfer(1, 2'h1, 0, 12'h000, 0, 0, 0);
         `CHK(lat >= 5 && lat <= 8, 1'b1)
         `CHK(rdata, 32'h0000_0000)
         dec <= 1'b1;
         dreg <= 1'b1;
         xfer(0, 2'h3, 0, 12'h000, 32'h0000_0000, 0, 0);
         xfer(1, 2'h2, 0, 12'h120, 0, 0, 0);
         `CHK(rdata, 32'h0000_0003)
      end
   endtask

   task t_single_strap;
      begin
         dec <= 1'b1;
         reset_dut(0, 0, 1);
         xfer(1, 2'h0, 0, 12'h000, 0, 0, 0);
         `CHK(rdata, 32'h0000_0000)
         xfer(1, 2'h0, 0, 12'h120, 0, 0, 0);
         `CHK(rdata, 32'h0000_0001)
         dreg <= 1'b0;
         xfer(1, 2'h0, 0, 12'h000, 0, 0, 0);
         `CHK(ext_cnt > 0, 1'b1)
      end
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial begin
      reset_dut(1, 1, 1);
      t_reset_regs;
      t_id_write;
      t_retry;
      t_cache;
      t_delay_boot;
      t_miss;
      t_single_strap;
      results;
   end

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      results;
   end
endmodule // test_cbstr_top
